// file: inc/fault_regs_pkg.sv
// constants for the fault status, audio path and undervoltage register bank
package fault_regs_pkg;

   // ==========================================================
   // register offsets
   localparam logic [7:0] OFS_EVENT_ENABLE = 8'h09; // event_enable_register
   localparam logic [7:0] OFS_FAULT_FLAGS = 8'h0A; // fault_event_flags
   localparam logic [7:0] OFS_LED_CEILING = 8'h0B; // led_current_ceiling
   localparam logic [7:0] OFS_AUDIO_CTRL = 8'h0C; // audio_path_control
   localparam logic [7:0] OFS_PGA_START = 8'h0D; // pga_start_gain
   localparam logic [7:0] OFS_PGA_LIVE = 8'h0E; // pga_live_gain
   localparam logic [7:0] OFS_UV_DEBOUNCE = 8'h0F; // undervoltage_debounce
   localparam logic [7:0] OFS_UV_THRESHOLD = 8'h10; // undervoltage_threshold

   // ==========================================================
   // reset values
   localparam logic [7:0] RST_EVENT_ENABLE = 8'h00;
   localparam logic [7:0] RST_FAULT_FLAGS = 8'h00;
   localparam logic [3:0] RST_CEILING = 4'h0; // lowest ceiling, 3 mA
   localparam logic [3:0] RST_AUDIO_CTRL = 4'h0;
   localparam logic [5:0] RST_START_GAIN = 6'h00; // -12 dB
   localparam logic [5:0] RST_DEBOUNCE = 6'h0F;
   localparam logic [2:0] RST_UV_LEVEL = 3'h3; // 2.2 V

   // ==========================================================
   // field positions
   localparam int BIT_CLOCK_LOSS = 7;
   localparam int BIT_UNDERVOLTAGE = 6;
   localparam int BIT_OVERHEAT = 5;
   localparam int BIT_WATCHDOG = 4;
   localparam int BIT_FW_VERSION = 3;
   localparam int BIT_FLASH_FAIL = 2;
   localparam int BIT_CORE_CHECK = 1;
   localparam int BIT_PROGRAM_DONE = 0;
   localparam int BIT_PRECHARGE = 3;
   localparam int BIT_PGA_BYPASS = 2;
   localparam int BIT_AUTO_GAIN = 1;
   localparam int BIT_AUDIO_SYNC = 0;

   // ==========================================================
   // timing: one de-bounce step is 16 us
   localparam int CLK_PERIOD_PS = 4000; // 250 MHz
   localparam int UV_STEP_PS = 16000000; // 16 us
   localparam int UV_STEP_CYCLES = UV_STEP_PS / CLK_PERIOD_PS;

   // ==========================================================
   // undervoltage de-bounce states
   typedef enum logic [2:0] {
      UV_CLEAR = 3'b001,
      UV_WAIT = 3'b010,
      UV_FAULT = 3'b100
   } uv_state_t;

endpackage

// file: hw/fault_status_audio_uvlo_regs.sv
// fault status, audio path, pga gain and undervoltage register bank
`timescale 1ns/1ps
// ==========================================================
module fault_status_audio_uvlo_regs import fault_regs_pkg::*; #(
   parameter int STEP_CYCLES = UV_STEP_CYCLES // cycles per 16 us de-bounce step
) (
   input wire logic core_clk, // core clock, 250 MHz
   input wire logic rst, // synchronous reset, active high
   input wire logic clk_en, // low freezes all state
   input wire logic [7:0] reg_addr, // register offset
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe, one cycle
   input wire logic reg_rd, // read strobe, one cycle
   output logic [7:0] reg_rdata, // read data, registered
   output logic reg_rvalid, // read data valid, one cycle
   input wire logic clock_loss_event, // clock loss detected, pulse
   input wire logic overheat_event, // over-temperature, pulse
   input wire logic watchdog_event, // watchdog fault, pulse
   input wire logic firmware_version_error_event, // firmware version error, pulse
   input wire logic flash_correction_fail_event, // flash correction failed, pulse
   input wire logic core_check_fail_event, // processor check failed, pulse
   input wire logic program_done_event, // functional program complete, pulse
   input wire logic undervoltage_raw, // comparator output, asynchronous
   input wire logic [5:0] applied_gain_code, // live pga gain from processor
   output logic [7:0] event_enable_register, // per-flag enables
   output logic [7:0] fault_event_flags, // sticky flags
   output logic [3:0] current_ceiling_code, // shared sink ceiling
   output logic adc_precharge_enable, // adc pre-charge on
   output logic pga_bypass_select, // adc fed from audio_input_pin
   output logic auto_gain_enable, // automatic gain on
   output logic audio_sync_enable, // audio sync on
   output logic audio_module_reset, // holds audio modules in reset
   output logic [5:0] initial_gain_code, // pga start gain
   output logic [5:0] undervoltage_debounce_count, // de-bounce steps
   output logic [2:0] undervoltage_level_code // detection level
);

   // ==========================================================
   // state of the bank
   typedef struct packed {
      logic [7:0] enable; // event enables
      logic [7:0] flags; // sticky event flags
      logic [3:0] ceiling; // current ceiling code
      logic [3:0] audio; // audio path control bits
      logic [5:0] start_gain; // initial gain code
      logic [5:0] debounce; // de-bounce step count
      logic [2:0] level; // undervoltage level code
      uv_state_t uv_state; // de-bounce state
      logic [11:0] step_cnt; // cycles inside one step
      logic [5:0] step_tally; // whole steps seen
      logic uv_meta; // first sync stage
      logic uv_sync; // second sync stage
      logic [7:0] rdata; // read data
      logic rvalid; // read answer strobe
   } bank_t;

   bank_t state_reg; // registered state
   bank_t state_next; // next state
   logic [7:0] event_in; // incoming events per bit
   logic [7:0] flag_set; // flag set terms
   logic [7:0] flags_after; // flags after set and clear
   logic uv_trip; // de-bounce completes this cycle
   logic clear_flags; // flag register read this cycle
   logic [7:0] read_mux; // read data selection
   logic [11:0] step_last; // last cycle index of one step

   assign step_last = 12'(STEP_CYCLES - 1);

   // event vector in flag order; bit 6 comes from the debouncer
   assign event_in[BIT_CLOCK_LOSS] = clock_loss_event;
   assign event_in[BIT_UNDERVOLTAGE] = uv_trip;
   assign event_in[BIT_OVERHEAT] = overheat_event;
   assign event_in[BIT_WATCHDOG] = watchdog_event;
   assign event_in[BIT_FW_VERSION] = firmware_version_error_event;
   assign event_in[BIT_FLASH_FAIL] = flash_correction_fail_event;
   assign event_in[BIT_CORE_CHECK] = core_check_fail_event;
   assign event_in[BIT_PROGRAM_DONE] = program_done_event;

   // a read of the flag word clears it so software sees each event once
   assign clear_flags = reg_rd && (reg_addr == OFS_FAULT_FLAGS);

   // ==========================================================
   // per-flag sticky logic: a set in the clearing cycle wins
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_flag
         assign flag_set[gi] = event_in[gi];
         assign flags_after[gi] = flag_set[gi] | (state_reg.flags[gi] & ~clear_flags);
      end
   endgenerate

   // ==========================================================
   // read data selection; unmapped offsets and reserved bits read zero
   always_comb begin
      case (reg_addr)
         OFS_EVENT_ENABLE: read_mux = state_reg.enable;
         OFS_FAULT_FLAGS: read_mux = state_reg.flags;
         OFS_LED_CEILING: read_mux = {4'h0, state_reg.ceiling};
         OFS_AUDIO_CTRL: read_mux = {4'h0, state_reg.audio};
         OFS_PGA_START: read_mux = {2'h0, state_reg.start_gain};
         OFS_PGA_LIVE: read_mux = {2'h0, applied_gain_code};
         OFS_UV_DEBOUNCE: read_mux = {2'h0, state_reg.debounce};
         OFS_UV_THRESHOLD: read_mux = {5'h00, state_reg.level};
         default: read_mux = 8'h00; // unmapped
      endcase
   end

   // ==========================================================
   // next-state logic
   always_comb begin
      state_next = state_reg;
      uv_trip = 1'b0;
      // two-stage synchroniser on the comparator level
      state_next.uv_meta = undervoltage_raw;
      state_next.uv_sync = state_reg.uv_meta;
      // undervoltage de-bounce: level must stay high for debounce steps
      case (state_reg.uv_state)
         UV_CLEAR: begin
            state_next.step_cnt = 12'h000;
            state_next.step_tally = 6'h00;
            if (state_reg.uv_sync) begin
               if (state_reg.debounce == 6'h00) begin
                  state_next.uv_state = UV_FAULT; // zero steps trips at once
                  uv_trip = 1'b1;
               end else begin
                  state_next.uv_state = UV_WAIT;
               end
            end
         end
         UV_WAIT: begin
            if (!state_reg.uv_sync) begin
               state_next.uv_state = UV_CLEAR; // bounce restarts the wait
            end else if (state_reg.step_cnt == step_last) begin
               state_next.step_cnt = 12'h000;
               state_next.step_tally = state_reg.step_tally + 6'h01;
               if (state_reg.step_tally + 6'h01 >= state_reg.debounce) begin
                  state_next.uv_state = UV_FAULT;
                  uv_trip = 1'b1;
               end
            end else begin
               state_next.step_cnt = state_reg.step_cnt + 12'h001;
            end
         end
         UV_FAULT: begin
            if (!state_reg.uv_sync) begin
               state_next.uv_state = UV_CLEAR;
            end
         end
         default: state_next.uv_state = UV_CLEAR;
      endcase
      state_next.flags = flags_after;
      // register writes; read-only offsets fall through untouched
      if (reg_wr) begin
         case (reg_addr)
            OFS_EVENT_ENABLE: state_next.enable = reg_wdata;
            OFS_LED_CEILING: state_next.ceiling = reg_wdata[3:0];
            OFS_AUDIO_CTRL: state_next.audio = reg_wdata[3:0];
            OFS_PGA_START: state_next.start_gain = reg_wdata[5:0];
            OFS_UV_DEBOUNCE: state_next.debounce = reg_wdata[5:0];
            OFS_UV_THRESHOLD: state_next.level = reg_wdata[2:0];
            default: state_next.enable = state_reg.enable;
         endcase
      end
      // read answer one cycle after the strobe
      state_next.rvalid = reg_rd;
      if (reg_rd) begin
         state_next.rdata = read_mux;
      end
   end

   // ==========================================================
   // state register with clock enable and synchronous reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg.enable <= RST_EVENT_ENABLE;
         state_reg.flags <= RST_FAULT_FLAGS;
         state_reg.ceiling <= RST_CEILING;
         state_reg.audio <= RST_AUDIO_CTRL;
         state_reg.start_gain <= RST_START_GAIN;
         state_reg.debounce <= RST_DEBOUNCE;
         state_reg.level <= RST_UV_LEVEL;
         state_reg.uv_state <= UV_CLEAR;
         state_reg.step_cnt <= 12'h000;
         state_reg.step_tally <= 6'h00;
         state_reg.uv_meta <= 1'b0;
         state_reg.uv_sync <= 1'b0;
         state_reg.rdata <= 8'h00;
         state_reg.rvalid <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // outputs, all from the state register; audio_module_reset through an inverter
   assign reg_rdata = state_reg.rdata;
   assign reg_rvalid = state_reg.rvalid;
   assign event_enable_register = state_reg.enable;
   assign fault_event_flags = state_reg.flags;
   // upper nibble never reaches the analog; a careless host cannot overdrive
   assign current_ceiling_code = state_reg.ceiling;
   assign adc_precharge_enable = state_reg.audio[BIT_PRECHARGE];
   assign pga_bypass_select = state_reg.audio[BIT_PGA_BYPASS];
   assign auto_gain_enable = state_reg.audio[BIT_AUTO_GAIN];
   assign audio_sync_enable = state_reg.audio[BIT_AUDIO_SYNC];
   assign audio_module_reset = ~state_reg.audio[BIT_AUDIO_SYNC];
   assign initial_gain_code = state_reg.start_gain;
   assign undervoltage_debounce_count = state_reg.debounce;
   assign undervoltage_level_code = state_reg.level;

   // ==========================================================
   // assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_clock_loss_sets: assert property (
      clk_en && clock_loss_event |=> fault_event_flags[BIT_CLOCK_LOSS])
      else $error("clock loss event did not set its flag");

   a_flags_read_clear: assert property (
      clk_en && reg_rd && reg_addr == OFS_FAULT_FLAGS && event_in == 8'h00
      |=> reg_rvalid && reg_rdata == $past(fault_event_flags) && fault_event_flags == 8'h00)
      else $error("flag read did not return and clear the flags");

   a_flags_no_write: assert property (
      clk_en && reg_wr && !reg_rd && reg_addr == OFS_FAULT_FLAGS && event_in == 8'h00
      |=> fault_event_flags == $past(fault_event_flags))
      else $error("write changed the read-only flags");

   a_ceiling_write: assert property (
      clk_en && reg_wr && reg_addr == OFS_LED_CEILING
      |=> current_ceiling_code == $past(reg_wdata[3:0]))
      else $error("ceiling code did not take the low nibble");

   a_audio_reset_hold: assert property (
      clk_en && reg_wr && reg_addr == OFS_AUDIO_CTRL
      |=> audio_module_reset == !$past(reg_wdata[BIT_AUDIO_SYNC]))
      else $error("audio modules not held in reset while disabled");

   a_uv_fault_flag: assert property (
      $rose(state_reg.uv_state == UV_FAULT) |-> fault_event_flags[BIT_UNDERVOLTAGE])
      else $error("undervoltage trip did not set its flag");

   a_uv_bounce_restart: assert property (
      clk_en && state_reg.uv_state == UV_WAIT && !state_reg.uv_sync
      |=> state_reg.uv_state == UV_CLEAR
          && fault_event_flags[BIT_UNDERVOLTAGE] == ($past(fault_event_flags[BIT_UNDERVOLTAGE])
          && !$past(clear_flags)))
      else $error("bouncing undervoltage did not restart de-bounce");

   a_live_gain_read: assert property (
      clk_en && reg_rd && reg_addr == OFS_PGA_LIVE
      |=> reg_rdata == {2'h0, $past(applied_gain_code)})
      else $error("live gain read returned wrong value");

   a_level_write: assert property (
      clk_en && reg_wr && reg_addr == OFS_UV_THRESHOLD
      |=> undervoltage_level_code == $past(reg_wdata[2:0]))
      else $error("undervoltage level did not take its write");

   // write paths of the remaining control registers and the sticky flag word
   a_enable_write: assert property (
      clk_en && reg_wr && reg_addr == OFS_EVENT_ENABLE
      |=> event_enable_register == $past(reg_wdata))
      else $error("enable register did not take its write");

   a_audio_write: assert property (
      clk_en && reg_wr && reg_addr == OFS_AUDIO_CTRL
      |=> {adc_precharge_enable, pga_bypass_select, auto_gain_enable, audio_sync_enable}
          == $past(reg_wdata[3:0]))
      else $error("audio path bits did not take their write");

   a_start_gain_write: assert property (
      clk_en && reg_wr && reg_addr == OFS_PGA_START
      |=> initial_gain_code == $past(reg_wdata[5:0]))
      else $error("initial gain did not take its write");

   a_debounce_write: assert property (
      clk_en && reg_wr && reg_addr == OFS_UV_DEBOUNCE
      |=> undervoltage_debounce_count == $past(reg_wdata[5:0]))
      else $error("de-bounce count did not take its write");

   a_event_sets_flag: assert property (
      clk_en && event_in != 8'h00
      |=> (fault_event_flags & $past(event_in)) == $past(event_in))
      else $error("event did not set its flag");

   a_flags_sticky: assert property (
      clk_en && !clear_flags
      |=> (fault_event_flags & $past(fault_event_flags)) == $past(fault_event_flags))
      else $error("flag dropped without a read of the flag word");

endmodule // fault_status_audio_uvlo_regs

// file: dv/host_model.sv
// host model that drives the register port of the fault status bank
`timescale 1ns/1ps
module host_model import fault_regs_pkg::*; (
   input wire logic core_clk, // core clock
   output logic [7:0] reg_addr, // register offset
   output logic [7:0] reg_wdata, // write data
   output logic reg_wr, // write strobe
   output logic reg_rd, // read strobe
   input wire logic [7:0] reg_rdata, // read answer
   input wire logic reg_rvalid // read answer valid
);
   // ==========================================================
   // idle bus at time zero
   initial begin
      reg_addr = 8'hFF;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // ==========================================================
   // one-cycle write; lines are inverted on release so stale data is never reused
   task automatic write(input logic [7:0] addr, input logic [7:0] data);
      logic [7:0] val;
      val = data;
      if (addr == OFS_LED_CEILING) begin
         val = {4'h0, data[3:0]};
      end
      @(posedge core_clk);
      reg_addr <= addr;
      reg_wdata <= val;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~addr;
      reg_wdata <= ~val;
      // return only once the written register has settled at the outputs
      #1;
   endtask

   // ==========================================================
   // one-cycle read; the answer stands in the cycle after the strobe
   task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic vld);
      @(posedge core_clk);
      reg_addr <= addr;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~addr;
      #1;
      vld = reg_rvalid;
      data = reg_rdata;
   endtask
endmodule // host_model

// file: dv/tb_top.sv
// self-checking testbench for the fault status register bank
`timescale 1ns/1ps
module tb_top import fault_regs_pkg::*;;
   logic core_clk, rst, uv_raw;
   logic [7:0] ev, a, wd, rdat, ena, flg;
   logic wr, rd, rv, ce, bp, ag, as, amr, pc;
   logic [5:0] live_gain, ig, dc;
   logic [3:0] ceil;
   logic [2:0] lvl;
   int bad_count = 0;
   int checked = 0;

   // ==========================================================
   // clock, reset and idle inputs
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      ev = 8'h00;
      uv_raw = 1'b0;
      live_gain = 6'h00;
   end

   host_model u_host (.core_clk(core_clk), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr),
      .reg_rd(rd), .reg_rdata(rdat), .reg_rvalid(rv));

   // short de-bounce step keeps the undervoltage run brief
   fault_status_audio_uvlo_regs #(.STEP_CYCLES(4)) u_dut (.core_clk(core_clk), .rst(rst),
      .clk_en(ce), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdat), .reg_rvalid(rv), .clock_loss_event(ev[7]), .overheat_event(ev[5]),
      .watchdog_event(ev[4]), .firmware_version_error_event(ev[3]),
      .flash_correction_fail_event(ev[2]), .core_check_fail_event(ev[1]),
      .program_done_event(ev[0]), .undervoltage_raw(uv_raw), .applied_gain_code(live_gain),
      .event_enable_register(ena), .fault_event_flags(flg), .current_ceiling_code(ceil),
      .adc_precharge_enable(pc), .pga_bypass_select(bp), .auto_gain_enable(ag),
      .audio_sync_enable(as), .audio_module_reset(amr), .initial_gain_code(ig),
      .undervoltage_debounce_count(dc), .undervoltage_level_code(lvl));

   // ==========================================================
   // compare helpers
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      logic v;
      u_host.read(addr, d, v);
      chk("rvalid", {7'h0, v}, 8'h01);
      chk("rdata", d, exp);
   endtask
   // waits for the undervoltage flag and gives the cycles it took, capped at 40
   task automatic uv_wait(output int n);
      n = 0;
      while (flg[BIT_UNDERVOLTAGE] !== 1'b1 && n < 40) begin
         @(posedge core_clk);
         #1;
         n++;
      end
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset();
      logic [7:0] rv_tab [0:7];
      rv_tab = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h03};
      for (int i = 0; i < 8; i++) begin
         rd_chk(OFS_EVENT_ENABLE + 8'(i), rv_tab[i]);
      end
      chk("audio reset", {7'h0, amr}, 8'h01);
   endtask
   task automatic t_rw();
      u_host.write(OFS_EVENT_ENABLE, 8'hA5);
      u_host.write(OFS_LED_CEILING, 8'h09);
      u_host.write(OFS_AUDIO_CTRL, 8'hFF);
      u_host.write(OFS_PGA_START, 8'hFF);
      u_host.write(OFS_UV_DEBOUNCE, 8'hFF);
      u_host.write(OFS_UV_THRESHOLD, 8'hFF);
      chk("enables", ena, 8'hA5);
      chk("ceiling", {4'h0, ceil}, 8'h09);
      chk("audio bits", {3'h0, pc, bp, ag, as, amr}, 8'h1E);
      chk("gain", {2'h0, ig}, 8'h3F);
      chk("deb", {2'h0, dc}, 8'h3F);
      chk("level", {5'h0, lvl}, 8'h07);
      rd_chk(OFS_AUDIO_CTRL, 8'h0F);
      rd_chk(OFS_PGA_START, 8'h3F);
      rd_chk(OFS_UV_THRESHOLD, 8'h07);
      u_host.write(OFS_AUDIO_CTRL, 8'h0A);
      chk("audio bits", {3'h0, pc, bp, ag, as, amr}, 8'h15);
   endtask
   // a write while the clock enable is low must leave the bank untouched
   task automatic t_freeze();
      @(posedge core_clk);
      ce <= 1'b0;
      u_host.write(OFS_LED_CEILING, 8'h03);
      chk("frozen ceiling", {4'h0, ceil}, 8'h09);
      @(posedge core_clk);
      ce <= 1'b1;
      rd_chk(OFS_LED_CEILING, 8'h09);
   endtask
   task automatic t_readonly();
      @(posedge core_clk);
      live_gain <= 6'h2B;
      u_host.write(OFS_FAULT_FLAGS, 8'hFF);
      u_host.write(OFS_PGA_LIVE, 8'hFF);
      u_host.write(8'h20, 8'h55);
      rd_chk(OFS_FAULT_FLAGS, 8'h00);
      rd_chk(OFS_PGA_LIVE, 8'h2B);
      rd_chk(8'h20, 8'h00);
      rd_chk(OFS_EVENT_ENABLE, 8'hA5);
   endtask
   task automatic t_events();
      logic [7:0] d;
      logic v;
      for (int i = 0; i < 8; i++) begin
         if (i != BIT_UNDERVOLTAGE) begin
            @(posedge core_clk);
            ev <= 8'h01 << i;
            @(posedge core_clk);
            ev <= 8'h00;
            #1;
            chk("flag port", flg, 8'h01 << i);
            rd_chk(OFS_FAULT_FLAGS, 8'h01 << i);
         end
      end
      rd_chk(OFS_FAULT_FLAGS, 8'h00);
      // an event in the cycle of the flag read survives the clear
      fork
         u_host.read(OFS_FAULT_FLAGS, d, v);
         begin
            @(posedge core_clk);
            ev <= 8'h01;
            @(posedge core_clk);
            ev <= 8'h00;
         end
      join
      chk("rvalid with event", {7'h0, v}, 8'h01);
      chk("read with event", d, 8'h00);
      rd_chk(OFS_FAULT_FLAGS, 8'h01);
      rd_chk(OFS_FAULT_FLAGS, 8'h00);
   endtask
   task automatic t_uv();
      int n;
      u_host.write(OFS_UV_DEBOUNCE, 8'h02);
      @(posedge core_clk);
      uv_raw <= 1'b1;
      repeat (5) @(posedge core_clk);
      uv_raw <= 1'b0;
      repeat (20) @(posedge core_clk);
      chk("glitch", flg, 8'h00);
      uv_raw <= 1'b1;
      uv_wait(n);
      // two sync flops, one cycle to leave idle, then two steps of four cycles
      chk("uv delay", n[7:0], 8'h0B);
      rd_chk(OFS_FAULT_FLAGS, 8'h40);
      // a zero count trips as soon as the synchronised level reaches the decoder
      @(posedge core_clk);
      uv_raw <= 1'b0;
      u_host.write(OFS_UV_DEBOUNCE, 8'h00);
      repeat (4) @(posedge core_clk);
      uv_raw <= 1'b1;
      uv_wait(n);
      chk("uv zero delay", n[7:0], 8'h03);
      rd_chk(OFS_FAULT_FLAGS, 8'h40);
      @(posedge core_clk);
      uv_raw <= 1'b0;
   endtask

   // ==========================================================
   // verdict and run order
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_rw();
      t_freeze();
      t_readonly();
      t_events();
      t_uv();
      // a second reset in mid-run must bring every written register back
      @(posedge core_clk);
      rst <= 1'b1;
      live_gain <= 6'h00;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      summarize();
   end
   // watchdog well beyond the few hundred cycles the scenarios need
   initial begin
      #40000;
      bad_count++;
      summarize();
   end
endmodule // tb_top
